//--- inc/fsp_pkg.sv
// Constants, codes and register map of the flash status and protection host
package fsp_pkg;
   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int CLK_MHZ   = 100;
   localparam int T_WP_NS   = 50;
   localparam int T_DH_NS   = 10;
   localparam int T_WPH_NS  = 50;
   localparam int T_SRA_NS  = 120;
   localparam int T_DF_NS   = 55;
   localparam int T_DPR_NS  = 700;
   localparam int CNT_W     = 8;
   localparam logic [CNT_W-1:0] WP_CYC  = CNT_W'((T_WP_NS * CLK_MHZ + 999) / 1000);
   localparam logic [CNT_W-1:0] DH_CYC  = CNT_W'((T_DH_NS * CLK_MHZ + 999) / 1000);
   localparam logic [CNT_W-1:0] WPH_CYC = CNT_W'((T_WPH_NS * CLK_MHZ + 999) / 1000);
   localparam logic [CNT_W-1:0] SRA_CYC = CNT_W'((T_SRA_NS * CLK_MHZ + 999) / 1000);
   localparam logic [CNT_W-1:0] DF_CYC  = CNT_W'((T_DF_NS * CLK_MHZ + 999) / 1000);
   localparam logic [CNT_W-1:0] DPR_CYC = CNT_W'((T_DPR_NS * CLK_MHZ + 999) / 1000);
   localparam logic [CNT_W-1:0] CNT_ONE = 8'h01;
   localparam logic [CNT_W-1:0] CNT_ZERO = 8'h00;
   // ----------------------------------------------------------------
   // Device command codes and addresses
   // ----------------------------------------------------------------
   localparam int AW = 20;
   localparam logic [7:0]    CMD_SETUP    = 8'h80;
   localparam logic [7:0]    CMD_LOCK     = 8'h20;
   localparam logic [7:0]    CMD_UNLOCK   = 8'h40;
   localparam logic [7:0]    CMD_SLEEP    = 8'hC0;
   localparam logic [7:0]    CMD_ABORT    = 8'hE0;
   localparam logic [7:0]    CMD_CLR_STAT = 8'h50;
   localparam logic [7:0]    CMD_RD_STAT  = 8'h70;
   localparam logic [7:0]    CMD_RD_ARRAY = 8'hF0;
   localparam logic [7:0]    CMD_READ_ID  = 8'h90;
   localparam logic [7:0]    UNLK_DATA1   = 8'hAA;
   localparam logic [7:0]    UNLK_DATA2   = 8'h55;
   localparam logic [AW-1:0] UNLK_ADDR1   = 20'h05555;
   localparam logic [AW-1:0] UNLK_ADDR2   = 20'h02AAA;
   localparam logic [AW-1:0] SECT_LO_ADDR = 20'h00000;
   localparam logic [AW-1:0] SECT_HI_ADDR = 20'hE0000;
   localparam logic [AW-1:0] ADDR_ZERO    = 20'h00000;
   // Device status word bits
   localparam int DQ_READY  = 7;
   localparam int DQ_SUSP   = 6;
   localparam int DQ_EFAIL  = 5;
   localparam int DQ_PFAIL  = 4;
   localparam logic [7:0] DQ_MASK = 8'hFC;
   // ----------------------------------------------------------------
   // APB register map
   // ----------------------------------------------------------------
   localparam logic [11:0] REG_CTRL  = 12'h000;
   localparam logic [11:0] REG_STAT  = 12'h004;
   localparam logic [11:0] REG_RDATA = 12'h008;
   localparam logic [11:0] REG_PIN   = 12'h00C;
   localparam logic [11:0] REG_ADDR  = 12'h010;
   localparam int CTRL_TOP_BIT  = 8;
   localparam int PIN_WP_BIT    = 0;
   localparam int PIN_PWD_BIT   = 1;
   localparam logic [1:0] PIN_RESET = 2'h2;
   localparam int STAT_BUSY_BIT = 0;
   localparam int STAT_RB_BIT   = 1;
   localparam int STAT_REC_BIT  = 2;
   localparam int STAT_FAIL_BIT = 3;
   localparam int STAT_WAKE_BIT = 4;
   localparam int STAT_CLR_BIT  = 5;
   localparam int STAT_DEV_LSB  = 8;

   typedef enum logic [3:0] {
      OP_NOP     = 4'h0,
      OP_LOCK    = 4'h1,
      OP_UNLOCK  = 4'h2,
      OP_SLEEP   = 4'h3,
      OP_ABORT   = 4'h4,
      OP_CLR     = 4'h5,
      OP_RDSTAT  = 4'h6,
      OP_RDARRAY = 4'h7,
      OP_ID      = 4'h8
   } fsp_op_t;
endpackage

//--- rtl/fsp_bus_cycle.sv
// One timed write or read cycle on the flash parallel pins
module fsp_bus_cycle (
   input  wire logic                  core_clk_i,
   input  wire logic                  rst_i,
   input  wire logic                  start_i,
   input  wire logic                  read_i,
   input  wire logic                  abort_i,
   input  wire logic [fsp_pkg::AW-1:0] addr_i,
   input  wire logic [7:0]            wdata_i,
   input  wire logic [7:0]            dq_i,
   output logic                       done_o,
   output logic [7:0]                 rdata_o,
   output logic [fsp_pkg::AW-1:0]     addr_o,
   output logic [7:0]                 dq_o,
   output logic                       dq_oe_o,
   output logic                       ce_n_o,
   output logic                       oe_n_o,
   output logic                       we_n_o
);
   import fsp_pkg::*;

   typedef enum logic [4:0] {
      BC_IDLE   = 5'h01,
      BC_SETUP  = 5'h02,
      BC_STROBE = 5'h04,
      BC_HOLD   = 5'h08,
      BC_RECOV  = 5'h10
   } fsp_bc_t;

   fsp_bc_t           st_q, st_d;
   logic [CNT_W-1:0]  cnt_q, cnt_d;
   logic              rd_q, rd_d, done_d, dq_oe_d, ce_n_d, oe_n_d, we_n_d;
   logic [7:0]        rdata_d, dq_d;
   logic [AW-1:0]     addr_d;

   // ----------------------------------------------------------------
   // Cycle sequencing
   // ----------------------------------------------------------------
   always_comb begin
      st_d = st_q;
      cnt_d = cnt_q;
      rd_d = rd_q;
      done_d = 1'b0;
      rdata_d = rdata_o;
      addr_d = addr_o;
      dq_d = dq_o;
      dq_oe_d = dq_oe_o;
      ce_n_d = ce_n_o;
      oe_n_d = oe_n_o;
      we_n_d = we_n_o;
      if (cnt_q != CNT_ZERO) begin
         cnt_d = cnt_q - CNT_ONE;
      end
      case (st_q)
         BC_IDLE: begin
            if (start_i) begin
               rd_d = read_i;
               addr_d = addr_i;
               dq_d = wdata_i;
               dq_oe_d = ~read_i;
               ce_n_d = 1'b0;
               st_d = BC_SETUP;
            end
         end
         BC_SETUP: begin
            // Status is latched on the later of the two falling enables
            we_n_d = rd_q;
            oe_n_d = ~rd_q;
            cnt_d = rd_q ? SRA_CYC : WP_CYC;
            st_d = BC_STROBE;
         end
         BC_STROBE: begin
            if (cnt_q == CNT_ONE) begin
               if (rd_q) begin
                  rdata_d = dq_i;
                  oe_n_d = 1'b1;
                  ce_n_d = 1'b1;
                  cnt_d = DF_CYC;
                  st_d = BC_RECOV;
               end else begin
                  we_n_d = 1'b1;
                  cnt_d = DH_CYC;
                  st_d = BC_HOLD;
               end
            end
         end
         BC_HOLD: begin
            if (cnt_q == CNT_ONE) begin
               dq_oe_d = 1'b0;
               ce_n_d = 1'b1;
               cnt_d = WPH_CYC;
               st_d = BC_RECOV;
            end
         end
         BC_RECOV: begin
            if (cnt_q == CNT_ONE) begin
               done_d = 1'b1;
               st_d = BC_IDLE;
            end
         end
         default: st_d = BC_IDLE;
      endcase
      if (abort_i) begin
         st_d = BC_IDLE;
         cnt_d = CNT_ZERO;
         done_d = 1'b0;
         dq_oe_d = 1'b0;
         ce_n_d = 1'b1;
         oe_n_d = 1'b1;
         we_n_d = 1'b1;
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         st_q <= BC_IDLE;
         cnt_q <= CNT_ZERO;
         rd_q <= 1'b0;
         done_o <= 1'b0;
         rdata_o <= 8'h00;
         addr_o <= ADDR_ZERO;
         dq_o <= 8'h00;
         dq_oe_o <= 1'b0;
         ce_n_o <= 1'b1;
         oe_n_o <= 1'b1;
         we_n_o <= 1'b1;
      end else begin
         st_q <= st_d;
         cnt_q <= cnt_d;
         rd_q <= rd_d;
         done_o <= done_d;
         rdata_o <= rdata_d;
         addr_o <= addr_d;
         dq_o <= dq_d;
         dq_oe_o <= dq_oe_d;
         ce_n_o <= ce_n_d;
         oe_n_o <= oe_n_d;
         we_n_o <= we_n_d;
      end
   end
endmodule

//--- rtl/fsp_host_ctrl.sv
// Host controller issuing status, lock and power commands to the flash
// Function
// - No program/erase while fail flag set; lock/unlock not refused on it
// - Host masks reserved status bits 1:0 in STAT, not in RDATA
// - Lock takes six writes, sector sixth
// - Unlock same six writes, unlock code
// - ID read: maker, device, lock info
// - Sleep ignored once erase suspended
// - After abort, read-array then clear status
// - Setup code after two unlock writes
module fsp_host_ctrl (
   input  wire logic                  core_clk_i,
   input  wire logic                  rst_i,
   input  wire logic                  psel_i,
   input  wire logic                  penable_i,
   input  wire logic                  pwrite_i,
   input  wire logic [11:0]           paddr_i,
   input  wire logic [31:0]           pwdata_i,
   output logic [31:0]                prdata_o,
   output logic                       pready_o,
   output logic                       pslverr_o,
   input  wire logic [7:0]            flash_dq_i,
   input  wire logic                  ready_busy_out_i,
   output logic [fsp_pkg::AW-1:0]     flash_addr_o,
   output logic [7:0]                 flash_dq_o,
   output logic                       flash_dq_oe_o,
   output logic                       flash_ce_n_o,
   output logic                       flash_oe_n_o,
   output logic                       flash_we_n_o,
   output logic                       flash_wp_o,
   output logic                       power_down_pin_n_o
);
   import fsp_pkg::*;

   typedef enum logic [2:0] {
      S_IDLE = 3'h1,
      S_RUN  = 3'h2,
      S_WAIT = 3'h4
   } fsp_state_t;

   // ----------------------------------------------------------------
   // Command table
   // ----------------------------------------------------------------
   function automatic logic [2:0] n_writes(input fsp_op_t op);
      case (op)
         OP_LOCK, OP_UNLOCK: n_writes = 3'h6;
         OP_SLEEP, OP_ABORT: n_writes = 3'h3;
         default:            n_writes = 3'h1;
      endcase
   endfunction

   function automatic logic [7:0] op_code(input fsp_op_t op);
      case (op)
         OP_LOCK:    op_code = CMD_LOCK;
         OP_UNLOCK:  op_code = CMD_UNLOCK;
         OP_SLEEP:   op_code = CMD_SLEEP;
         OP_ABORT:   op_code = CMD_ABORT;
         OP_CLR:     op_code = CMD_CLR_STAT;
         OP_RDSTAT:  op_code = CMD_RD_STAT;
         OP_RDARRAY: op_code = CMD_RD_ARRAY;
         default:    op_code = CMD_READ_ID;
      endcase
   endfunction

   function automatic logic needs_read(input fsp_op_t op);
      needs_read = (op != OP_CLR) && (op != OP_RDARRAY);
   endfunction

   fsp_state_t        st_q, st_d;
   fsp_op_t           op_q, op_d;
   logic              top_q, top_d;
   logic [2:0]        step_q, step_d;
   logic [1:0]        pin_q, pin_d;
   logic [AW-1:0]     id_addr_q, id_addr_d;
   logic [7:0]        dev_stat_q, dev_stat_d;
   logic [7:0]        rdata_q, rdata_d;
   logic              fail_q, fail_d, wake_q, wake_d, clr_q, clr_d;
   logic [CNT_W-1:0]  rec_q, rec_d;
   logic [31:0]       prdata_d;
   logic              pready_d, pslverr_d;
   logic              bc_done, bc_start, bc_read, bc_abort;
   logic [7:0]        bc_rdata, bc_wdata;
   logic [AW-1:0]     bc_addr;
   logic [2:0]        nw;
   logic [1:0]        slot;
   logic              setup_ph, commit, busy, refuse, pwd_fall, pwd_rise;
   fsp_op_t           new_op;

   assign nw = n_writes(op_q);
   assign busy = (st_q != S_IDLE) || (rec_q != CNT_ZERO);
   assign setup_ph = psel_i && !penable_i;
   assign commit = psel_i && penable_i && pready_o && pwrite_i && !pslverr_o;
   assign new_op = fsp_op_t'(pwdata_i[3:0]);
   assign pwd_fall = pin_q[PIN_PWD_BIT] && !pin_d[PIN_PWD_BIT];
   assign pwd_rise = !pin_q[PIN_PWD_BIT] && pin_d[PIN_PWD_BIT];
   assign slot = 2'(step_q % 3'h3);

   // ----------------------------------------------------------------
   // Command acceptance
   // ----------------------------------------------------------------
   always_comb begin
      refuse = busy || !pin_q[PIN_PWD_BIT];
      case (new_op)
         OP_LOCK, OP_UNLOCK: begin
            refuse = refuse || !pin_q[PIN_WP_BIT];
            refuse = refuse || wake_q || clr_q;
         end
         OP_SLEEP: refuse = refuse || dev_stat_q[DQ_SUSP];
         OP_ABORT, OP_CLR, OP_RDSTAT, OP_RDARRAY, OP_ID: refuse = refuse;
         default: refuse = 1'b1;
      endcase
   end

   // ----------------------------------------------------------------
   // Register bus
   // ----------------------------------------------------------------
   always_comb begin
      pready_d = setup_ph;
      pslverr_d = 1'b0;
      prdata_d = 32'h0000_0000;
      pin_d = pin_q;
      id_addr_d = id_addr_q;
      if (setup_ph) begin
         if (paddr_i == REG_CTRL) begin
            pslverr_d = pwrite_i && refuse;
         end else if (paddr_i == REG_STAT) begin
            prdata_d[STAT_BUSY_BIT] = busy;
            prdata_d[STAT_RB_BIT] = ready_busy_out_i;
            prdata_d[STAT_REC_BIT] = rec_q != CNT_ZERO;
            prdata_d[STAT_FAIL_BIT] = fail_q;
            prdata_d[STAT_WAKE_BIT] = wake_q;
            prdata_d[STAT_CLR_BIT] = clr_q;
            prdata_d[STAT_DEV_LSB +: 8] = dev_stat_q;
         end else if (paddr_i == REG_RDATA) begin
            prdata_d[7:0] = rdata_q;
         end else if (paddr_i == REG_PIN) begin
            prdata_d[1:0] = pin_q;
         end else if (paddr_i == REG_ADDR) begin
            prdata_d[AW-1:0] = id_addr_q;
         end else begin
            pslverr_d = 1'b1;
         end
      end
      if (commit && paddr_i == REG_PIN) begin
         pin_d = pwdata_i[1:0];
      end
      if (commit && paddr_i == REG_ADDR) begin
         id_addr_d = pwdata_i[AW-1:0];
      end
   end

   // ----------------------------------------------------------------
   // Command sequencer
   // ----------------------------------------------------------------
   always_comb begin
      st_d = st_q;
      op_d = op_q;
      top_d = top_q;
      step_d = step_q;
      dev_stat_d = dev_stat_q;
      rdata_d = rdata_q;
      fail_d = fail_q;
      wake_d = wake_q;
      clr_d = clr_q;
      rec_d = rec_q;
      bc_start = 1'b0;
      bc_read = step_q >= nw;
      bc_addr = UNLK_ADDR1;
      bc_wdata = op_code(op_q);
      bc_abort = 1'b0;
      if (rec_q != CNT_ZERO) begin
         rec_d = rec_q - CNT_ONE;
      end
      if (bc_read) begin
         bc_addr = (op_q == OP_ID) ? id_addr_q : ADDR_ZERO;
      end else if (step_q == nw - 3'h1) begin
         if (op_q == OP_LOCK || op_q == OP_UNLOCK) begin
            bc_addr = top_q ? SECT_HI_ADDR : SECT_LO_ADDR;
         end
      end else if (slot == 2'h1) begin
         bc_addr = UNLK_ADDR2;
         bc_wdata = UNLK_DATA2;
      end else if (slot == 2'h2) begin
         bc_wdata = CMD_SETUP;
      end else begin
         bc_wdata = UNLK_DATA1;
      end
      case (st_q)
         S_IDLE: begin
            if (commit && paddr_i == REG_CTRL) begin
               op_d = new_op;
               top_d = pwdata_i[CTRL_TOP_BIT];
               step_d = 3'h0;
               st_d = S_RUN;
            end
         end
         S_RUN: begin
            bc_start = 1'b1;
            st_d = S_WAIT;
         end
         S_WAIT: begin
            if (bc_done && !bc_read) begin
               step_d = step_q + 3'h1;
               st_d = (step_d < nw || needs_read(op_q)) ? S_RUN : S_IDLE;
               if (op_q == OP_RDARRAY) begin
                  wake_d = 1'b0;
               end
               if (op_q == OP_CLR) begin
                  fail_d = 1'b0;
                  clr_d = 1'b0;
                  dev_stat_d = dev_stat_q & ~8'h30;
               end
            end else if (bc_done) begin
               rdata_d = bc_rdata;
               st_d = S_IDLE;
               if (op_q != OP_ID) begin
                  dev_stat_d = bc_rdata & DQ_MASK;
                  if (!bc_rdata[DQ_READY]) begin
                     st_d = S_RUN;
                  end else begin
                     case (op_q)
                        OP_LOCK:   fail_d = fail_q || bc_rdata[DQ_EFAIL];
                        OP_UNLOCK: fail_d = fail_q || bc_rdata[DQ_PFAIL];
                        default: begin
                           fail_d = fail_q || bc_rdata[DQ_EFAIL] || bc_rdata[DQ_PFAIL];
                        end
                     endcase
                     if (op_q == OP_SLEEP || op_q == OP_ABORT) begin
                        wake_d = 1'b1;
                     end
                     if (op_q == OP_ABORT) begin
                        clr_d = 1'b1;
                     end
                  end
               end
            end
         end
         default: st_d = S_IDLE;
      endcase
      if (!pin_q[PIN_PWD_BIT]) begin
         bc_abort = 1'b1;
         st_d = S_IDLE;
      end
      if (pwd_fall) begin
         dev_stat_d = 8'h00;
         wake_d = 1'b0;
      end
      if (pwd_rise) begin
         rec_d = DPR_CYC;
      end
   end

   fsp_bus_cycle u_bus (
      .core_clk_i (core_clk_i),
      .rst_i      (rst_i),
      .start_i    (bc_start),
      .read_i     (bc_read),
      .abort_i    (bc_abort),
      .addr_i     (bc_addr),
      .wdata_i    (bc_wdata),
      .dq_i       (flash_dq_i),
      .done_o     (bc_done),
      .rdata_o    (bc_rdata),
      .addr_o     (flash_addr_o),
      .dq_o       (flash_dq_o),
      .dq_oe_o    (flash_dq_oe_o),
      .ce_n_o     (flash_ce_n_o),
      .oe_n_o     (flash_oe_n_o),
      .we_n_o     (flash_we_n_o)
   );

   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         st_q <= S_IDLE;
         op_q <= OP_NOP;
         top_q <= 1'b0;
         step_q <= 3'h0;
         pin_q <= PIN_RESET;
         id_addr_q <= ADDR_ZERO;
         dev_stat_q <= 8'h00;
         rdata_q <= 8'h00;
         fail_q <= 1'b0;
         wake_q <= 1'b0;
         clr_q <= 1'b0;
         rec_q <= CNT_ZERO;
         prdata_o <= 32'h0000_0000;
         pready_o <= 1'b0;
         pslverr_o <= 1'b0;
         flash_wp_o <= PIN_RESET[PIN_WP_BIT];
         power_down_pin_n_o <= PIN_RESET[PIN_PWD_BIT];
      end else begin
         st_q <= st_d;
         op_q <= op_d;
         top_q <= top_d;
         step_q <= step_d;
         pin_q <= pin_d;
         id_addr_q <= id_addr_d;
         dev_stat_q <= dev_stat_d;
         rdata_q <= rdata_d;
         fail_q <= fail_d;
         wake_q <= wake_d;
         clr_q <= clr_d;
         rec_q <= rec_d;
         prdata_o <= prdata_d;
         pready_o <= pready_d;
         pslverr_o <= pslverr_d;
         flash_wp_o <= pin_d[PIN_WP_BIT];
         power_down_pin_n_o <= pin_d[PIN_PWD_BIT];
      end
   end
endmodule

//--- verif/fsp_flash_model.sv
// Behavioural flash device for the status, lock, id and power commands
module fsp_flash_model #(
   parameter logic [7:0] MAKER_ID = 8'h5A, // Arbitrary value
   parameter logic [7:0] DEV_ID   = 8'hA5  // Arbitrary value
) (
   input  wire logic [19:0] addr_i,
   input  wire logic [7:0]  dq_i,
   input  wire logic        ce_n_i,
   input  wire logic        oe_n_i,
   input  wire logic        we_n_i,
   input  wire logic        wp_i,
   input  wire logic        pdn_n_i,
   output logic [7:0]       dq_o,
   output logic             ready_busy_out_o
);
   // Reserved bits 1:0 read as ones so that the host must mask them
   logic [7:0]  st = 8'h83;
   logic [7:0]  q = 8'h00;
   logic [47:0] sq = '0;
   logic [1:0]  lk = 2'b00;
   logic [1:0]  md = 2'b00;
   logic        fail_next = 1'b0;
   assign ready_busy_out_o = st[7];
   // deselected bus shows the inverse of the last byte, no pull-up
   assign dq_o = (!ce_n_i && !oe_n_i && pdn_n_i) ? q : ~q;
   always @(negedge oe_n_i)
      if (!ce_n_i)
         q = md == 2 ? (addr_i[3:0] == 0 ? MAKER_ID : addr_i[3:0] == 1 ? DEV_ID : {6'h0, lk})
           : md == 1 ? {st[7:4], |lk, st[2:0]} : 8'hFF;
   always @(negedge pdn_n_i) st = 8'h83;
   always @(posedge we_n_i) if (!ce_n_i && pdn_n_i) begin
      sq = {sq[39:0], dq_i};
      if (sq[47:8] == 40'hAA5580AA55 && wp_i && (addr_i == 20'h00000 || addr_i == 20'hE0000)
          && (dq_i == 8'h20 || dq_i == 8'h40)) begin
         md = 1;
         st[7] = 1'b0;
         st[5:4] <= #300 st[5:4] | ({dq_i == 8'h20, dq_i == 8'h40} & {2{fail_next}});
         if (!fail_next) lk[addr_i[19]] <= #300 dq_i == 8'h20;
         st[7] <= #300 1'b1;
      end
      else if (sq[23:8] == 16'hAA55 && (dq_i == 8'hC0 || dq_i == 8'hE0)) begin
         md = 1;
         st[2] = 1'b1;
      end
      else case (dq_i)
         8'hF0: begin md = 0; st[2] = 1'b0; end
         8'h50: st[5:4] = 2'b00;
         8'h70: md = 1;
         8'h90: md = 2;
         default: ;
      endcase
   end
endmodule

//--- verif/fsp_host_ctrl_chk.sv
// Port checker for the flash status and protection host
module fsp_host_ctrl_chk (
   input wire logic              core_clk_i,
   input wire logic              rst_i,
   input wire logic              psel_i,
   input wire logic              penable_i,
   input wire logic              pwrite_i,
   input wire logic [11:0]       paddr_i,
   input wire logic [31:0]       pwdata_i,
   input wire logic              pready_o,
   input wire logic              pslverr_o,
   input wire logic [19:0]       flash_addr_o,
   input wire logic [7:0]        flash_dq_o,
   input wire logic              flash_dq_oe_o,
   input wire logic              flash_ce_n_o,
   input wire logic              flash_oe_n_o,
   input wire logic              flash_we_n_o,
   input wire logic              flash_wp_o,
   input wire logic              power_down_pin_n_o
);
   default clocking @(posedge core_clk_i); endclocking
   default disable iff (rst_i);
   property p_rdy; psel_i && !penable_i |=> pready_o; endproperty
   a_rdy: assert property (p_rdy) else $error("no ready after setup");
   property p_err; pslverr_o |-> pready_o; endproperty
   a_err: assert property (p_err) else $error("error without ready");
   property p_unmap; psel_i && !penable_i && paddr_i > 12'h010 |=> pslverr_o; endproperty
   a_unmap: assert property (p_unmap) else $error("unmapped not refused");
   property p_pulse; $fell(flash_we_n_o) |-> (!flash_we_n_o)[*5]; endproperty
   a_pulse: assert property (p_pulse) else $error("write pulse short");
   property p_wctx; !flash_we_n_o |-> !flash_ce_n_o && flash_dq_oe_o && flash_oe_n_o; endproperty
   a_wctx: assert property (p_wctx) else $error("bad write strobes");
   property p_rctx; !flash_oe_n_o |-> !flash_ce_n_o && !flash_dq_oe_o && flash_we_n_o; endproperty
   a_rctx: assert property (p_rctx) else $error("bad read strobes");
   property p_hold;
      !flash_we_n_o && $past(!flash_we_n_o) |-> $stable(flash_addr_o) && $stable(flash_dq_o);
   endproperty
   a_hold: assert property (p_hold) else $error("write data moved");
   property p_pdn;
      !power_down_pin_n_o && $past(!power_down_pin_n_o)
         |-> flash_ce_n_o && flash_oe_n_o && flash_we_n_o;
   endproperty
   a_pdn: assert property (p_pdn) else $error("strobe during power-down");
   property p_pin;
      psel_i && penable_i && pready_o && pwrite_i && paddr_i == 12'h00C && !pslverr_o
         |=> flash_wp_o == $past(pwdata_i[0]) && power_down_pin_n_o == $past(pwdata_i[1]);
   endproperty
   a_pin: assert property (p_pin) else $error("pin write lost");
   property p_rec; $rose(power_down_pin_n_o) |-> flash_ce_n_o[*8]; endproperty
   a_rec: assert property (p_rec) else $error("access in recovery");
   c_wr: cover property ($fell(flash_we_n_o));
   c_rd: cover property ($fell(flash_oe_n_o));
   c_pd: cover property ($fell(power_down_pin_n_o));
endmodule
bind fsp_host_ctrl fsp_host_ctrl_chk chk (.core_clk_i, .rst_i, .psel_i, .penable_i, .pwrite_i,
   .paddr_i, .pwdata_i, .pready_o, .pslverr_o, .flash_addr_o, .flash_dq_o, .flash_dq_oe_o,
   .flash_ce_n_o, .flash_oe_n_o, .flash_we_n_o, .flash_wp_o, .power_down_pin_n_o);

//--- verif/tb_top.sv
// Testbench for the flash status and protection host
module tb_top;
   timeunit 1ns;
   timeprecision 100ps;
   import fsp_pkg::*;
   logic        clk = 0, rst = 1, psel = 0, pen = 0, pwr = 0, e;
   logic [11:0] paddr = '0;
   logic [31:0] pwdata = '0, prdata, r;
   logic        pready, pslverr, dq_oe, ce_n, oe_n, we_n, wp, pdn_n, rb;
   logic [19:0] fa;
   logic [7:0]  dq_h, dq_d, dq_w;
   int          miscompares = 0, check_count = 0, cyc = 0;
   always #5 clk = ~clk;
   // Wire level from both drivers
   assign dq_w = dq_oe ? dq_h : dq_d;
   fsp_host_ctrl dut (.core_clk_i(clk), .rst_i(rst), .psel_i(psel), .penable_i(pen),
      .pwrite_i(pwr), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
      .pready_o(pready), .pslverr_o(pslverr), .flash_dq_i(dq_w), .ready_busy_out_i(rb),
      .flash_addr_o(fa), .flash_dq_o(dq_h), .flash_dq_oe_o(dq_oe), .flash_ce_n_o(ce_n),
      .flash_oe_n_o(oe_n), .flash_we_n_o(we_n), .flash_wp_o(wp), .power_down_pin_n_o(pdn_n));
   fsp_flash_model flash (.addr_i(fa), .dq_i(dq_w), .ce_n_i(ce_n), .oe_n_i(oe_n),
      .we_n_i(we_n), .wp_i(wp), .pdn_n_i(pdn_n), .dq_o(dq_d), .ready_busy_out_o(rb));
   task automatic final_report;
      $display("checks %0d miscompares %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 30000) begin
         miscompares++;
         final_report;
      end
   end
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      pwr <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      pen <= 1'b1;
      // Answer and read data are taken at the edge that sees pready high
      do begin
         @(posedge clk);
      end while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      pen <= 1'b0;
   endtask
   task automatic cmp(input logic [31:0] g, x);
      check_count++;
      if (g !== x) begin
         miscompares++;
         $display("ERROR %0t got %h expected %h", $time, g, x);
      end
   endtask
   // Order an operation, then poll until idle if no refusal is expected
   task automatic op(input logic [31:0] c, input logic x);
      apb(1'b1, REG_CTRL, c);
      cmp(32'(e), 32'(x));
      r = 32'h1;
      while (!x && r[STAT_BUSY_BIT] !== 1'b0) apb(1'b0, REG_STAT, 32'h0);
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] m, x);
      apb(1'b0, a, 32'h0);
      cmp(r & m, x);
   endtask
   task automatic id(input logic [31:0] a, x);
      apb(1'b1, REG_ADDR, a);
      op(32'h8, 1'b0);
      rd(REG_RDATA, 32'hFF, x);
   endtask
   initial begin
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      rd(REG_PIN, 32'h3, 32'h2);
      rd(12'h020, 32'hFFFFFFFF, 32'h0);
      cmp(32'(e), 32'h1);
      op(32'h0, 1'b1);
      op(32'h1, 1'b1);
      apb(1'b1, REG_PIN, 32'h3);
      op(32'h1, 1'b0);
      rd(REG_STAT, 32'hFF0A, 32'h8802);
      id(32'h2, 32'h01);
      op(32'h101, 1'b0);
      id(32'h2, 32'h03);
      id(32'h0, 32'h5A);
      id(32'h1, 32'hA5);
      op(32'h102, 1'b0);
      rd(REG_STAT, 32'hFF08, 32'h8800);
      $display("test lock done");
      flash.fail_next = 1'b1;
      op(32'h101, 1'b0);
      rd(REG_STAT, 32'hFF08, 32'hA808);
      flash.fail_next = 1'b0;
      op(32'h5, 1'b0);
      rd(REG_STAT, 32'hFF08, 32'h8800);
      $display("test fail done");
      op(32'h3, 1'b0);
      rd(REG_STAT, 32'hFF10, 32'h8C10);
      op(32'h1, 1'b1);
      op(32'h7, 1'b0);
      rd(REG_STAT, 32'h10, 32'h0);
      op(32'h4, 1'b0);
      rd(REG_STAT, 32'h30, 32'h30);
      op(32'h7, 1'b0);
      op(32'h1, 1'b1);
      op(32'h5, 1'b0);
      rd(REG_STAT, 32'h30, 32'h0);
      $display("test sleep done");
      flash.st[6] = 1'b1;
      op(32'h6, 1'b0);
      rd(REG_STAT, 32'hFF00, 32'hC800);
      op(32'h3, 1'b1);
      flash.st[6] = 1'b0;
      apb(1'b1, REG_CTRL, 32'h101);
      rd(REG_STAT, 32'h1, 32'h1);
      // Drop power-down in the middle of the first lock write
      apb(1'b1, REG_PIN, 32'h1);
      rd(REG_STAT, 32'h1, 32'h0);
      rd(REG_STAT, 32'hFF00, 32'h0);
      op(32'h1, 1'b1);
      apb(1'b1, REG_PIN, 32'h3);
      rd(REG_STAT, 32'h4, 32'h4);
      op(32'h7, 1'b1);
      repeat (80) @(posedge clk);
      op(32'h7, 1'b0);
      $display("test power done");
      final_report;
   end
endmodule
